// file: hw/tws_serial_io.sv
/*
 * tws_serial_io: 8-bit three-wire serial port with an APB register slave.
 * assumes: pclk is the main oscillator clock; sck and si pins are
 * asynchronous; pad logic resolves the pins from the output enables.
 */
`timescale 1ns/1ps
module tws_serial_io
    import tws_pkg::*;
(
    input  wire logic              pclk,     // main clock, 250 MHz
    input  wire logic              presetn,  // async reset, low
    input  wire logic              psel,     // apb select
    input  wire logic              penable,  // apb access phase
    input  wire logic              pwrite,   // apb direction
    input  wire logic [ADDR_W-1:0] paddr,    // apb byte address
    input  wire logic [31:0]       pwdata,   // apb write data
    input  wire logic [3:0]        pstrb,    // apb byte strobes
    output logic      [31:0]       prdata,   // apb read data
    output logic                   pready,   // apb ready
    output logic                   pslverr,  // apb error, unmapped
    input  wire logic              sck_i,    // serial clock pin level
    output logic                   sck_o,    // serial clock drive
    output logic                   sck_oe,   // serial clock enable
    output logic                   so_o,     // serial out drive
    output logic                   so_oe,    // serial out enable
    input  wire logic              si_i,     // serial in pin level
    output logic                   serial_active // pins owned by port
);
    typedef struct packed {
        logic [7:0]  mode_ctrl;
        logic        busy;
        logic        sck_level;
        logic [3:0]  bit_cnt;
        logic        done;
        logic        so_latch;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } tws_state_t;

    tws_state_t s_reg;
    tws_state_t s_next;

    logic [7:0] shift_reg;
    logic [7:0] shift_next;

    logic       sck_mid;
    logic       sck_last;
    logic       si_mid;
    logic       si_last;
    logic       div_tick;

    logic       enabled;
    logic       rx_only;
    logic [1:0] clk_sel;
    logic       ext_clk;
    logic       setup_ph;
    logic       access_ph;
    logic       hit_ctrl;
    logic       hit_data;
    logic       hit_stat;
    logic       start_ok;
    logic       fall_ev;
    logic       rise_ev;
    logic       trig_wr;
    logic       trig_rd;

    tws_pin_sync
    #(
        .W       (2),
        .RST_VAL (2'b11)
    )
    u_sync
    (
        .clk    (pclk),
        .rst_n  (presetn),
        .d      ({sck_i, si_i}),
        .q_mid  ({sck_mid, si_mid}),
        .q_last ({sck_last, si_last})
    );

    tws_clk_div u_div
    (
        .clk   (pclk),
        .rst_n (presetn),
        .run   (s_reg.busy && !ext_clk),
        .sel   (clk_sel),
        .tick  (div_tick)
    );

    assign enabled  = s_reg.mode_ctrl[BIT_ENABLE];
    assign rx_only  = s_reg.mode_ctrl[BIT_RX_ONLY];
    assign clk_sel  = {s_reg.mode_ctrl[BIT_CLK_HI], s_reg.mode_ctrl[BIT_CLK_LO]};
    assign ext_clk  = (clk_sel == CLK_EXTERNAL);

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable && s_reg.ready;
    assign hit_ctrl  = (paddr == ADDR_MODE_CTRL);
    assign hit_data  = (paddr == ADDR_SHIFT_DATA);
    assign hit_stat  = (paddr == ADDR_STATUS);

    // a new transfer starts only if the clock is idle high at the request
    assign start_ok = enabled && !s_reg.busy
                      && (!ext_clk || (sck_mid && sck_last));

    // external edges count while stage two shows the new level and stage three still the old
    assign fall_ev = ext_clk ? (sck_last && !sck_mid && sck_mid == sck_mid)
                             : (div_tick && s_reg.sck_level);
    assign rise_ev = ext_clk ? (!sck_last && sck_mid)
                             : (div_tick && !s_reg.sck_level);

    assign trig_wr = access_ph && pwrite && hit_data && pstrb[0]
                     && !rx_only && start_ok;
    assign trig_rd = access_ph && !pwrite && hit_data
                     && rx_only && start_ok;

    always_comb
    begin
        s_next     = s_reg;
        shift_next = shift_reg;

        // apb: data and error latched in setup, answered in the access cycle
        s_next.ready  = setup_ph;
        s_next.slverr = 1'b0;
        if (setup_ph)
        begin
            s_next.slverr = !(hit_ctrl || hit_data || hit_stat);
            s_next.rdata  = 32'h0000_0000;
            if (hit_ctrl)
                s_next.rdata = {24'h00_0000, s_reg.mode_ctrl & CTRL_WR_MASK};
            else if (hit_data)
                s_next.rdata = {24'h00_0000, shift_reg};
            else if (hit_stat)
                s_next.rdata = {30'h0000_0000, s_reg.busy, s_reg.done};
        end

        if (access_ph && pwrite && pstrb[0])
        begin
            if (hit_ctrl)
                s_next.mode_ctrl = pwdata[7:0] & CTRL_WR_MASK;
            else if (hit_data && !s_reg.busy)
                shift_next = pwdata[7:0];
            else if (hit_stat && pwdata[BIT_DONE])
                s_next.done = 1'b0;
        end

        if (trig_wr || trig_rd)
        begin
            s_next.busy      = 1'b1;
            s_next.bit_cnt   = 4'h0;
            s_next.sck_level = 1'b1;
        end

        if (s_reg.busy)
        begin
            if (fall_ev)
            begin
                s_next.sck_level = 1'b0;
                s_next.so_latch  = shift_reg[7];
                shift_next       = {shift_reg[6:0], shift_reg[0]};
            end
            else if (rise_ev)
            begin
                s_next.sck_level = 1'b1;
                shift_next[0]    = si_mid;
                s_next.bit_cnt   = s_reg.bit_cnt + 4'h1;
                if (s_reg.bit_cnt == LAST_BIT)
                begin
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                end
            end
        end

        // disable aborts any transfer and clears the counter
        if (!s_next.mode_ctrl[BIT_ENABLE])
        begin
            s_next.busy      = 1'b0;
            s_next.bit_cnt   = 4'h0;
            s_next.sck_level = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg           <= '0;
            s_reg.mode_ctrl <= CTRL_RESET;
            s_reg.sck_level <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // shift data has no reset and powers up undefined
    always_ff @(posedge pclk)
    begin
        shift_reg <= shift_next;
    end

    assign prdata  = s_reg.rdata;
    assign pready  = s_reg.ready;
    assign pslverr = s_reg.slverr && s_reg.ready;

    assign serial_active = enabled;
    assign sck_o  = s_reg.sck_level;
    assign sck_oe = enabled && !ext_clk;
    assign so_o   = rx_only ? 1'b0 : s_reg.so_latch;
    assign so_oe  = enabled;

endmodule // tws_serial_io

// file: hw/tws_pkg.sv
/*
 * tws_pkg: register map, field positions, reset values and divider counts
 * of the three-wire serial port.
 * assumes: APB with 32-bit data, one aligned word per register.
 */
package tws_pkg;

    localparam int          ADDR_W         = 20;

    // register indices; byte address is four times the index
    localparam logic [17:0] IDX_MODE_CTRL  = 18'h0ff86;
    localparam logic [17:0] IDX_SHIFT_DATA = 18'h0ff87;
    localparam logic [17:0] IDX_STATUS     = 18'h0ff88;

    localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL  = {IDX_MODE_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SHIFT_DATA = {IDX_SHIFT_DATA, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = {IDX_STATUS, 2'b00};

    // serial_mode_control fields
    localparam int          BIT_ENABLE     = 7;
    localparam int          BIT_RX_ONLY    = 2;
    localparam int          BIT_CLK_HI     = 1;
    localparam int          BIT_CLK_LO     = 0;
    localparam logic [7:0]  CTRL_WR_MASK   = 8'h87;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;

    // status fields
    localparam int          BIT_DONE       = 0;
    localparam int          BIT_BUSY       = 1;

    // clock select codes
    localparam logic [1:0]  CLK_EXTERNAL   = 2'b00;
    localparam logic [1:0]  CLK_DIV8       = 2'b01;
    localparam logic [1:0]  CLK_DIV16      = 2'b10;
    localparam logic [1:0]  CLK_DIV32      = 2'b11;

    // divide ratios of the main clock and the derived half-period counts
    localparam int          DIV8_RATIO     = 8;
    localparam int          DIV16_RATIO    = 16;
    localparam int          DIV32_RATIO    = 32;
    localparam int          HALF_W         = 4;
    localparam logic [HALF_W-1:0] HALF_DIV8  = HALF_W'(DIV8_RATIO / 2 - 1);
    localparam logic [HALF_W-1:0] HALF_DIV16 = HALF_W'(DIV16_RATIO / 2 - 1);
    localparam logic [HALF_W-1:0] HALF_DIV32 = HALF_W'(DIV32_RATIO / 2 - 1);

    localparam int          XFER_BITS      = 8;
    localparam logic [3:0]  LAST_BIT       = 4'(XFER_BITS - 1);

endpackage

// file: hw/tws_pin_sync.sv
/*
 * tws_pin_sync: three-stage synchroniser for pin inputs.
 * assumes: inputs asynchronous to clk; callers read only q_mid and q_last.
 */
`timescale 1ns/1ps
module tws_pin_sync
#(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input  wire logic         clk,     // system clock
    input  wire logic         rst_n,   // async reset, low
    input  wire logic [W-1:0] d,       // raw pin levels
    output logic      [W-1:0] q_mid,   // second stage
    output logic      [W-1:0] q_last   // third stage
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= RST_VAL;
            q_mid    <= RST_VAL;
            q_last   <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            q_mid    <= meta_reg;
            q_last   <= q_mid;
        end
    end
endmodule // tws_pin_sync

// file: hw/tws_clk_div.sv
/*
 * tws_clk_div: half-period tick generator for the internal serial clock.
 * assumes: sel is steady while run is high.
 */
`timescale 1ns/1ps
module tws_clk_div
    import tws_pkg::*;
(
    input  wire logic       clk,    // main clock
    input  wire logic       rst_n,  // async reset, low
    input  wire logic       run,    // count while high
    input  wire logic [1:0] sel,    // clock select code
    output logic            tick    // one-cycle pulse per half period
);
    logic [HALF_W-1:0] cnt_reg;
    logic [HALF_W-1:0] limit;

    always_comb
    begin
        unique case (sel)
            CLK_DIV8:  limit = HALF_DIV8;
            CLK_DIV16: limit = HALF_DIV16;
            CLK_DIV32: limit = HALF_DIV32;
            default:   limit = HALF_DIV32;
        endcase
    end

    assign tick = run && (cnt_reg == limit);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_reg <= '0;
        else if (!run || tick)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + 1'b1;
    end
endmodule // tws_clk_div

// file: test/tws_serial_io_sva.sv
/*
 * tws_serial_io_sva: port-level checks of the three-wire serial port.
 * assumes: bound to tws_serial_io; pclk is the only clock.
 */
`timescale 1ns/1ps
module tws_serial_io_sva
    import tws_pkg::*;
(
    input wire logic              pclk,          // clock
    input wire logic              presetn,       // reset, low
    input wire logic              psel,          // apb select
    input wire logic              penable,       // apb access
    input wire logic              pwrite,        // apb direction
    input wire logic [ADDR_W-1:0] paddr,         // apb address
    input wire logic [31:0]       pwdata,        // apb write data
    input wire logic [3:0]        pstrb,         // apb strobes
    input wire logic [31:0]       prdata,        // apb read data
    input wire logic              pready,        // apb ready
    input wire logic              sck_o,         // serial clock drive
    input wire logic              sck_oe,        // serial clock enable
    input wire logic              so_o,          // serial out drive
    input wire logic              so_oe,         // serial out enable
    input wire logic              serial_active  // pins owned
);
    logic [7:0] ctrl_reg;
    logic [2:0] age_reg;
    wire        en      = ctrl_reg[BIT_ENABLE];
    wire        settled = age_reg > 3'h2;

    // mirror of mode/control and cycles since its last write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= CTRL_RESET;
            age_reg  <= 3'h0;
        end
        else if (psel && penable && pready && pwrite && paddr == ADDR_MODE_CTRL && pstrb[0])
        begin
            ctrl_reg <= pwdata[7:0] & CTRL_WR_MASK;
            age_reg  <= 3'h0;
        end
        else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_rx_so_low:
        assert property (settled && en && ctrl_reg[BIT_RX_ONLY] |-> !so_o)
            else $error("serial out high in receive-only mode");
    a_off_release:
        assert property (settled && !en |-> !so_oe && !sck_oe && !serial_active && sck_o)
            else $error("pins held while port disabled");
    a_on_own:
        assert property (settled && en |-> so_oe && serial_active)
            else $error("pins not owned while port enabled");
    a_clk_select:
        assert property (settled && en |-> sck_oe == (ctrl_reg[1:0] != CLK_EXTERNAL))
            else $error("clock drive does not follow clock select");
    a_half_div8:
        assert property (settled && sck_oe && ctrl_reg[1:0] == CLK_DIV8 && $fell(sck_o)
            |-> (!sck_o)[*4] ##1 sck_o) else $error("divide-by-8 half period wrong");
    a_half_div16:
        assert property (settled && sck_oe && ctrl_reg[1:0] == CLK_DIV16 && $fell(sck_o)
            |-> (!sck_o)[*8] ##1 sck_o) else $error("divide-by-16 half period wrong");
    a_so_on_fall:
        assert property (settled && en && sck_oe && !ctrl_reg[BIT_RX_ONLY] && $changed(so_o)
            |-> $fell(sck_o)) else $error("serial out moved off a falling clock");
    a_ctrl_read:
        assert property (psel && penable && pready && !pwrite && paddr == ADDR_MODE_CTRL
            |-> prdata == {24'h0, ctrl_reg}) else $error("mode/control read back wrong");

    cover property (en && ctrl_reg[BIT_RX_ONLY] && $fell(sck_o));
    cover property (en && ctrl_reg[1:0] == CLK_EXTERNAL && so_oe);
    cover property (en && ctrl_reg[1:0] == CLK_DIV16 && $rose(sck_o));
endmodule // tws_serial_io_sva

bind tws_serial_io tws_serial_io_sva i_tws_serial_io_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .sck_o(sck_o), .sck_oe(sck_oe),
    .so_o(so_o), .so_oe(so_oe), .serial_active(serial_active));

// file: test/tws_peer.sv
/*
 * tws_peer: far-side clocked serial device, msb first, optional clock source.
 * assumes: sck is the resolved clock line; load precedes each transfer.
 */
`timescale 1ns/1ps
module tws_peer
(
    input  wire logic       pclk,    // bench clock
    input  wire logic       sck,     // clock line
    input  wire logic       so,      // line from port
    input  wire logic       load,    // arm for a transfer
    input  wire logic       ext_go,  // supply eight pulses
    input  wire logic [7:0] tx,      // byte to send
    output logic            si,      // line to port
    output logic            sck_drv, // external clock drive
    output logic [7:0]      rx       // byte received
);
    logic [3:0] cnt;

    initial si = 1'b1;
    initial sck_drv = 1'b1;
    always @(posedge pclk)
        if (load)
            cnt <= 4'h0;
    // capture on rise, present next bit on fall
    always @(posedge sck)
    begin
        rx  <= {rx[6:0], so};
        cnt <= cnt + 4'h1;
    end
    always @(negedge sck)
        if (cnt < 4'h8)
            si <= tx[3'(4'h7 - cnt)];
    // eight pulses of six cycles a level, idle high
    always @(posedge pclk)
        if (ext_go)
            repeat (8)
            begin
                repeat (6) @(posedge pclk);
                sck_drv <= 1'b0;
                repeat (6) @(posedge pclk);
                sck_drv <= 1'b1;
            end
endmodule // tws_peer

// file: test/testbench.sv
/*
 * testbench: register-level tests of the serial port against a far-side model.
 * assumes: tws_pkg register map; clock line resolved from the output enable.
 */
`timescale 1ns/1ps
module testbench
    import tws_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              sck_o, sck_oe, so_o, so_oe, serial_active, si_line, p_sck;
    logic              load, ext_go, e;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, r;
    logic [3:0]        pstrb;
    logic [7:0]        p_tx, p_rx;
    logic [7:0]        modes [5] = '{8'h81, 8'h82, 8'h83, 8'h85, 8'h80};
    int                errors, samples_checked, cycles;
    wire               sck_line = sck_oe ? sck_o : p_sck;
    wire               so_line  = so_oe ? so_o : 1'b1;

    tws_serial_io i_tws_serial_io (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_i(sck_line),
        .sck_o(sck_o), .sck_oe(sck_oe), .so_o(so_o), .so_oe(so_oe), .si_i(si_line),
        .serial_active(serial_active));
    tws_peer i_tws_peer (.pclk(pclk), .sck(sck_line), .so(so_line), .load(load),
        .ext_go(ext_go), .tx(p_tx), .si(si_line), .sck_drv(p_sck), .rx(p_rx));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic xfer(input logic [7:0] c, input logic [7:0] d, input logic [7:0] pb);
        @(posedge pclk);
        p_tx <= pb;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        apb(1'b1, ADDR_MODE_CTRL, {24'h0, c});
        apb(!c[BIT_RX_ONLY], ADDR_SHIFT_DATA, {24'h0, d});
        ext_go <= (c[1:0] == CLK_EXTERNAL);
        @(posedge pclk);
        ext_go <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("busy", r[BIT_BUSY], 1'b1);
        for (int k = 0; k < 300 && r[BIT_DONE] !== 1'b1; k++)
            apb(1'b0, ADDR_STATUS, 32'h0);
        chk("done", r, 32'h1);
        chk("far_rx", p_rx, c[BIT_RX_ONLY] ? 8'h00 : d);
        // stop mode first, so a receive-only read does not start another transfer
        apb(1'b1, ADDR_MODE_CTRL, {24'h0, c & 8'h7f});
        apb(1'b0, ADDR_SHIFT_DATA, 32'h0);
        chk("shift_rx", r, {24'h0, pb});
        apb(1'b1, ADDR_STATUS, 32'h1);
    endtask

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        presetn = 1'b0;
        load = 1'b0;
        ext_go = 1'b0;
        p_tx = 8'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_MODE_CTRL, 32'h0);
        chk("ctrl_reset", r, 32'h0);
        apb(1'b1, ADDR_MODE_CTRL, 32'h78);
        apb(1'b1, 20'h00010, 32'hff);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        apb(1'b0, ADDR_MODE_CTRL, 32'h0);
        chk("ctrl_reserved", r, 32'h0);
        apb(1'b1, ADDR_SHIFT_DATA, 32'h3c);
        apb(1'b0, ADDR_SHIFT_DATA, 32'h0);
        chk("stop_rw", r, 32'h3c);
        apb(1'b1, ADDR_MODE_CTRL, 32'h82);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("no_start", r, 32'h0);
        foreach (modes[i])
            xfer(modes[i], 8'ha5 ^ 8'(i * 17), 8'h3c + 8'(i * 9));
        apb(1'b1, ADDR_MODE_CTRL, 32'h83);
        apb(1'b1, ADDR_SHIFT_DATA, 32'h5a);
        repeat (40) @(posedge pclk);
        apb(1'b1, ADDR_MODE_CTRL, 32'h03);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("abort", r, 32'h0);
        conclude();
    end
endmodule // testbench
